// >>> sfh_pkg.sv
package sfh_pkg;
    // power-transition recovery window
    localparam int RECOVERY_US = 10;
    localparam int CLK_MHZ = 10;
    // least time, exact whole cycles at this rate
    localparam int RECOVERY_CYC = RECOVERY_US * CLK_MHZ;
    localparam logic [7:0] RECOVERY_LOAD = 8'(RECOVERY_CYC);
    // array geometry of the attached device
    localparam int PAGES_PER_BLOCK = 32;
    localparam int HALF_PAGE_BYTES = 256;
    localparam int SPARE_BYTES = 16;
    localparam int MAIN_WORDS = 256;
    localparam int SPARE_WORDS = 8;
    localparam int BLOCKS_TOTAL = 4096;
    localparam int BLOCKS_MIN_VALID = 4016;
    // address layout: column byte, then 17 page bits
    localparam int COL_W = 8;
    localparam int PAGE_W = 17;
    localparam int PIB_W = 5;
    localparam int BLOCK_W = 12;
    localparam logic [1:0] ADDR_LAST = 2'h3;
    localparam logic [2:0] ADDR_CYCLES = 3'h4;
    // bad block table size
    localparam int BAD_SLOTS = 4;
    localparam logic [1:0] BAD_PTR_RST = 2'h0;
    localparam logic [15:0] BUS_RST = 16'h0000;

    // user request kinds
    typedef enum logic [2:0] {
        SFH_OP_CMD = 3'h0,
        SFH_OP_ADDR = 3'h1,
        SFH_OP_WRITE = 3'h2,
        SFH_OP_READ = 3'h3,
        SFH_OP_WAIT = 3'h4,
        SFH_OP_MARK = 3'h5
    } sfh_op_type;

    // sequencer states
    typedef enum logic [2:0] {
        SFH_ST_PWR = 3'h0,
        SFH_ST_IDLE = 3'h1,
        SFH_ST_SETUP = 3'h2,
        SFH_ST_STROBE = 3'h3,
        SFH_ST_HOLD = 3'h4,
        SFH_ST_BUSYW = 3'h5
    } sfh_state_type;

    // one user request
    typedef struct packed {
        sfh_op_type op;
        logic [15:0] data;
        logic [COL_W-1:0] column;
        logic [PAGE_W-1:0] page;
    } sfh_req_type;

    // control pins towards the flash, all active levels as on the wire
    typedef struct packed {
        logic ce_n;
        logic command_latch_select;
        logic address_latch_select;
        logic we_n;
        logic re_n;
        logic wp_n;
    } sfh_pins_type;

    // reset pins: deselected, both latch selects low, strobes high, protect low
    localparam sfh_pins_type PINS_RST = 6'h26;
endpackage

// >>> sfh_timer.sv
`timescale 1ns/1ps
`default_nettype none
module sfh_timer
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_load,
    output logic o_expired
);
    // remaining recovery cycles, starts full at reset
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    // reload on request, else count down to zero
    assign cnt_d = i_load ? sfh_pkg::RECOVERY_LOAD :
                   (cnt_q != 8'h00) ? cnt_q - 8'h01 : cnt_q;
    assign o_expired = (cnt_q == 8'h00);

    // counter register
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            cnt_q <= sfh_pkg::RECOVERY_LOAD;
        else
            cnt_q <= cnt_d;
    end
endmodule
`default_nettype wire

// >>> sfh_ctrl.sv
// Functional notes
// RQ1 - blocks hold 32 pages, main plus spare
// RQ2 - byte pages: two 256-byte halves, 16 spare
// RQ3 - word pages: 256 words plus 8 spare
// RQ4 - host tracks and avoids bad blocks
// RQ5 - device latches bus on write rising edge
// RQ6 - device floats bus when deselected; the model drives ~last_q instead
// RQ7 - commands and addresses use low byte only
// RQ8 - address select high marks address byte
// RQ9 - command select high marks command byte
// RQ10 - device ignores bus while deselected
// RQ11 - program or erase survives deselect
// RQ12 - host holds select low during read busy
// RQ13 - select-insensitive variant keeps read running
// RQ14 - read falling edge advances column
// RQ15 - device refuses commands 10 us after power
// RQ16 - host keeps write high during recovery
// RQ17 - write protect low blocks program, erase
// RQ18 - host holds write protect low at power
// RQ19 - device pulls busy low during operations
// RQ20 - busy is wired-and, low means busy
// RQ21 - device disabled below supply lockout
// RQ22 - address is four low-byte latch cycles
// RQ23 - data write: select low, latches low, read high
// RQ24 - device model detects strobe edges
`timescale 1ns/1ps
`default_nettype none
module sfh_ctrl
(
    input wire logic I_CLK,
    input wire logic I_RST_B,
    input wire logic I_REQ_VALID,
    input wire sfh_pkg::sfh_req_type I_REQ,
    output logic O_REQ_READY,
    output logic O_DONE,
    output logic O_ERR,
    output logic [15:0] O_RDATA,
    input wire logic I_PWR_DOWN,
    input wire logic I_WP_RELEASE,
    input wire logic I_WORD_WIDE,
    output sfh_pkg::sfh_pins_type O_PINS,
    output logic [15:0] O_BUS_OUT,
    output logic O_BUS_OE_LO,
    output logic O_BUS_OE_HI,
    input wire logic [15:0] I_BUS_IN,
    input wire logic I_READY_BUSY_OD
);
    // pick one address byte of a request, low byte lanes only
    function automatic logic [7:0] addr_byte(input sfh_pkg::sfh_req_type r, input logic [1:0] idx);
        logic [7:0] b;
        b = r.column;
        unique case (idx)
            2'h0: b = r.column;
            2'h1: b = r.page[7:0];
            2'h2: b = r.page[15:8];
            2'h3: b = {7'h00, r.page[16]};
        endcase
        return b;
    endfunction

    // sequencer state
    sfh_pkg::sfh_state_type state_q;
    sfh_pkg::sfh_state_type state_d;
    // latched request and the byte index of an address
    sfh_pkg::sfh_req_type req_q;
    sfh_pkg::sfh_req_type req_d;
    logic [1:0] byte_q;
    logic [1:0] byte_d;
    // pin and bus registers
    sfh_pkg::sfh_pins_type pins_q;
    sfh_pkg::sfh_pins_type pins_d;
    logic [15:0] bus_q;
    logic [15:0] bus_d;
    logic oe_lo_q;
    logic oe_lo_d;
    logic oe_hi_q;
    logic oe_hi_d;
    // user answer registers
    logic ready_q;
    logic done_q;
    logic done_d;
    logic err_q;
    logic err_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    // bad block table
    logic [sfh_pkg::BLOCK_W-1:0] bad_q [sfh_pkg::BAD_SLOTS];
    logic [sfh_pkg::BAD_SLOTS-1:0] bad_vld_q;
    logic [1:0] bad_ptr_q;
    logic [sfh_pkg::BAD_SLOTS-1:0] bad_hit;
    // recovery timer status
    logic recov_done;
    logic timer_load;

    // request decode
    wire accept = (state_q == sfh_pkg::SFH_ST_IDLE) && ready_q && I_REQ_VALID && !I_PWR_DOWN;
    wire [sfh_pkg::BLOCK_W-1:0] req_block = I_REQ.page[sfh_pkg::PAGE_W-1:sfh_pkg::PIB_W];
    wire hit_any = |bad_hit;
    wire is_addr = accept && (I_REQ.op == sfh_pkg::SFH_OP_ADDR);
    wire refuse = is_addr && hit_any; // [RQ4]
    wire mark = accept && (I_REQ.op == sfh_pkg::SFH_OP_MARK);
    wire last_byte = (req_q.op != sfh_pkg::SFH_OP_ADDR) || (byte_q == sfh_pkg::ADDR_LAST);
    // operation in flight for the next state
    wire sfh_pkg::sfh_op_type op_n = accept ? I_REQ.op : req_q.op;
    wire busy_st = (state_d == sfh_pkg::SFH_ST_SETUP) || (state_d == sfh_pkg::SFH_ST_STROBE) ||
                   (state_d == sfh_pkg::SFH_ST_HOLD);
    wire strobe_st = (state_d == sfh_pkg::SFH_ST_STROBE);

    // compare request block against every table slot
    genvar g;
    generate
        for (g = 0; g < sfh_pkg::BAD_SLOTS; g++)
        begin : g_bad
            assign bad_hit[g] = bad_vld_q[g] && (bad_q[g] == req_block); // [RQ4]
        end
    endgenerate

    // recovery timer, reloaded on each entry to the power state
    sfh_timer u_timer
    (
        .i_clk(I_CLK),
        .i_rst_b(I_RST_B),
        .i_load(timer_load),
        .o_expired(recov_done)
    );
    assign timer_load = (state_q != sfh_pkg::SFH_ST_PWR) && (state_d == sfh_pkg::SFH_ST_PWR);

    // next state
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            sfh_pkg::SFH_ST_PWR:
                // leave only after full recovery and with power good
                if (recov_done && !I_PWR_DOWN)
                    state_d = sfh_pkg::SFH_ST_IDLE; // [RQ16]
            sfh_pkg::SFH_ST_IDLE:
                if (I_PWR_DOWN)
                    state_d = sfh_pkg::SFH_ST_PWR; // [RQ16]
                else if (accept && I_REQ.op == sfh_pkg::SFH_OP_WAIT)
                    state_d = sfh_pkg::SFH_ST_BUSYW;
                else if (accept && !refuse && !mark)
                    state_d = sfh_pkg::SFH_ST_SETUP;
            sfh_pkg::SFH_ST_SETUP:
                state_d = sfh_pkg::SFH_ST_STROBE;
            sfh_pkg::SFH_ST_STROBE:
                state_d = sfh_pkg::SFH_ST_HOLD;
            sfh_pkg::SFH_ST_HOLD:
                // further address bytes loop back to setup
                state_d = last_byte ? sfh_pkg::SFH_ST_IDLE : sfh_pkg::SFH_ST_SETUP; // [RQ22]
            sfh_pkg::SFH_ST_BUSYW:
                // any low on the shared line means some device is busy
                if (I_READY_BUSY_OD)
                    state_d = sfh_pkg::SFH_ST_IDLE; // [RQ20]
            default:
                state_d = sfh_pkg::SFH_ST_PWR;
        endcase
    end

    // request and address byte bookkeeping
    assign req_d = accept ? I_REQ : req_q;
    assign byte_d = accept ? 2'h0 :
                    (state_q == sfh_pkg::SFH_ST_HOLD && !last_byte) ? byte_q + 2'h1 : byte_q;

    // pin levels follow the next state so outputs leave flip-flops
    assign pins_d.ce_n = (state_d == sfh_pkg::SFH_ST_PWR); // [RQ12]
    assign pins_d.command_latch_select = busy_st && (op_n == sfh_pkg::SFH_OP_CMD);
    assign pins_d.address_latch_select = busy_st && (op_n == sfh_pkg::SFH_OP_ADDR); // [RQ22]
    assign pins_d.we_n = !(strobe_st && (op_n != sfh_pkg::SFH_OP_READ)); // [RQ16] [RQ23]
    assign pins_d.re_n = !(strobe_st && (op_n == sfh_pkg::SFH_OP_READ)); // [RQ23]
    assign pins_d.wp_n = (state_d != sfh_pkg::SFH_ST_PWR) && I_WP_RELEASE; // [RQ18]
    // drive the bus for writes only; high byte only for wide data
    assign oe_lo_d = busy_st && (op_n != sfh_pkg::SFH_OP_READ);
    assign oe_hi_d = busy_st && (op_n == sfh_pkg::SFH_OP_WRITE) && I_WORD_WIDE; // [RQ7]

    // bus value: command and address on the low byte, upper byte zero
    assign bus_d = !accept ? ((state_q == sfh_pkg::SFH_ST_HOLD && !last_byte) ?
                               {8'h00, addr_byte(req_q, byte_q + 2'h1)} : bus_q) :
                   (I_REQ.op == sfh_pkg::SFH_OP_WRITE) ? I_REQ.data :
                   (I_REQ.op == sfh_pkg::SFH_OP_ADDR) ? {8'h00, addr_byte(I_REQ, 2'h0)} :
                   {8'h00, I_REQ.data[7:0]}; // [RQ7] [RQ22]

    // answers
    assign done_d = (state_d == sfh_pkg::SFH_ST_IDLE) &&
                    ((state_q == sfh_pkg::SFH_ST_HOLD) || (state_q == sfh_pkg::SFH_ST_BUSYW) || refuse || mark);
    assign err_d = refuse; // [RQ4]
    assign rdata_d = (state_q == sfh_pkg::SFH_ST_STROBE && req_q.op == sfh_pkg::SFH_OP_READ) ?
                     {I_WORD_WIDE ? I_BUS_IN[15:8] : 8'h00, I_BUS_IN[7:0]} : rdata_q;

    // sequencer and pin registers
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            state_q <= sfh_pkg::SFH_ST_PWR;
            req_q <= '0;
            byte_q <= 2'h0;
            pins_q <= sfh_pkg::PINS_RST;
            bus_q <= sfh_pkg::BUS_RST;
            oe_lo_q <= 1'b0;
            oe_hi_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            req_q <= req_d;
            byte_q <= byte_d;
            pins_q <= pins_d;
            bus_q <= bus_d;
            oe_lo_q <= oe_lo_d;
            oe_hi_q <= oe_hi_d;
        end
    end

    // user answer registers
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            ready_q <= 1'b0;
            done_q <= 1'b0;
            err_q <= 1'b0;
            rdata_q <= 16'h0000;
        end
        else
        begin
            ready_q <= (state_d == sfh_pkg::SFH_ST_IDLE);
            done_q <= done_d;
            err_q <= err_d;
            rdata_q <= rdata_d;
        end
    end

    // bad block table, filled round robin
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
        begin
            bad_vld_q <= '0;
            bad_ptr_q <= sfh_pkg::BAD_PTR_RST;
            for (int i = 0; i < sfh_pkg::BAD_SLOTS; i++)
                bad_q[i] <= '0;
        end
        else if (mark)
        begin
            bad_q[bad_ptr_q] <= req_block; // [RQ4]
            bad_vld_q[bad_ptr_q] <= 1'b1;
            bad_ptr_q <= bad_ptr_q + 2'h1;
        end
    end

    assign O_REQ_READY = ready_q;
    assign O_DONE = done_q;
    assign O_ERR = err_q;
    assign O_RDATA = rdata_q;
    assign O_PINS = pins_q;
    assign O_BUS_OUT = bus_q;
    assign O_BUS_OE_LO = oe_lo_q;
    assign O_BUS_OE_HI = oe_hi_q;

    // helper: write rising edges seen while address select is high
    logic [2:0] als_cnt_q;
    always_ff @(posedge I_CLK or negedge I_RST_B)
    begin
        if (!I_RST_B)
            als_cnt_q <= 3'h0;
        else if (!pins_q.address_latch_select)
            als_cnt_q <= 3'h0;
        else if (!pins_q.we_n && pins_d.we_n)
            als_cnt_q <= als_cnt_q + 3'h1;
    end

    // bad block address is answered with an error and never strobed
    property p_bad_refused;
        @(posedge I_CLK) disable iff (!I_RST_B)
        refuse |=> O_ERR && O_DONE && !O_PINS.address_latch_select ##1 !O_PINS.address_latch_select;
    endproperty
    a_bad_refused: assert property (p_bad_refused) else $error("bad block address not refused"); // [RQ4]

    // latch phases keep the upper lanes released and zero
    property p_low_byte_only;
        @(posedge I_CLK) disable iff (!I_RST_B)
        (O_PINS.command_latch_select || O_PINS.address_latch_select) |-> !O_BUS_OE_HI && O_BUS_OE_LO &&
            (O_BUS_OUT[15:8] == 8'h00);
    endproperty
    a_low_byte_only: assert property (p_low_byte_only) else $error("upper byte used for command or address"); // [RQ7]

    // select stays low while waiting on busy
    property p_select_in_busy;
        @(posedge I_CLK) disable iff (!I_RST_B)
        (state_q == sfh_pkg::SFH_ST_BUSYW) |-> !O_PINS.ce_n && O_PINS.we_n && O_PINS.re_n;
    endproperty
    a_select_in_busy: assert property (p_select_in_busy) else $error("select released during busy wait"); // [RQ12]

    // recovery: write strobe high, no command, no request taken
    property p_recovery_quiet;
        @(posedge I_CLK) disable iff (!I_RST_B)
        (state_q == sfh_pkg::SFH_ST_PWR) |-> O_PINS.we_n && !O_PINS.command_latch_select && !O_REQ_READY;
    endproperty
    a_recovery_quiet: assert property (p_recovery_quiet) else $error("activity during recovery"); // [RQ16]

    // write protect low across power transitions
    property p_wp_at_power;
        @(posedge I_CLK) disable iff (!I_RST_B)
        $rose(state_q == sfh_pkg::SFH_ST_PWR) |-> !O_PINS.wp_n [*8];
    endproperty
    a_wp_at_power: assert property (p_wp_at_power) else $error("write protect released at power"); // [RQ18]

    // a low busy line keeps the wait going; high ends it next cycle
    property p_busy_wired;
        @(posedge I_CLK) disable iff (!I_RST_B)
        (state_q == sfh_pkg::SFH_ST_BUSYW) && $past(state_q == sfh_pkg::SFH_ST_BUSYW) |->
            ($past(I_READY_BUSY_OD) == 1'b0) ##1 (O_DONE == $past(I_READY_BUSY_OD));
    endproperty
    a_busy_wired: assert property (p_busy_wired) else $error("busy line misread"); // [RQ20]

    // an address burst holds exactly four write strobes
    property p_four_addr;
        @(posedge I_CLK) disable iff (!I_RST_B)
        $fell(O_PINS.address_latch_select) |-> (als_cnt_q == sfh_pkg::ADDR_CYCLES) && O_DONE;
    endproperty
    a_four_addr: assert property (p_four_addr) else $error("address burst not four cycles"); // [RQ22]

    // data strobe only with select low and read strobe high
    property p_data_write;
        @(posedge I_CLK) disable iff (!I_RST_B)
        (!O_PINS.we_n && !O_PINS.command_latch_select && !O_PINS.address_latch_select) |->
            O_PINS.re_n && !O_PINS.ce_n && O_BUS_OE_LO ##1 O_PINS.we_n && O_BUS_OE_LO;
    endproperty
    a_data_write: assert property (p_data_write) else $error("bad data write cycle"); // [RQ23]
endmodule
`default_nettype wire

// >>> sfh_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfh_flash_model
#(
    parameter int BUSY_CYC = 20,
    parameter logic [7:0] BUSY_CMD = 8'h30
)
(
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire sfh_pkg::sfh_pins_type i_pins,
    input wire logic [15:0] i_dq,
    output logic [15:0] o_dq,
    output logic o_rb_low
);
    // one page main area; byte view uses the low lane of each word
    logic [15:0] mem_q [0:255];
    logic [7:0] col_q;
    logic [7:0] cmd_q;
    logic [7:0] adr_q [0:3];
    logic [1:0] acnt_q;
    logic [15:0] last_q;
    int rec_q;
    int bsy_q;
    logic we_q;
    logic re_q;
    // strobe edges seen by oversampling, only while selected
    wire sel = ~i_pins.ce_n;
    wire we_rise = sel & i_pins.we_n & ~we_q;
    wire re_fall = sel & ~i_pins.re_n & re_q;
    // drive only while read strobe low, else show a changed value
    assign o_dq = (sel & ~i_pins.re_n) ? mem_q[col_q] : ~last_q;
    // open drain pull-down during recovery and operations
    assign o_rb_low = (rec_q != 0) | (bsy_q != 0);
    // latch logic; busy counts on whatever select does
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            for (int k = 0; k < 256; k++) mem_q[k] <= 16'hFFFF;
            for (int k = 0; k < 4; k++) adr_q[k] <= 8'h00;
            {col_q, cmd_q, acnt_q, last_q, bsy_q} <= '0;
            rec_q <= sfh_pkg::RECOVERY_CYC;
            {we_q, re_q} <= 2'h3;
        end
        else
        begin
            we_q <= i_pins.we_n;
            re_q <= i_pins.re_n;
            if (rec_q != 0) rec_q <= rec_q - 1;
            if (bsy_q != 0) bsy_q <= bsy_q - 1;
            // nothing latched on write strobes until recovery ends
            if (we_rise && rec_q == 0)
            begin
                if (i_pins.command_latch_select)
                begin
                    cmd_q <= i_dq[7:0];
                    acnt_q <= 2'h0;
                    if (i_dq[7:0] == BUSY_CMD) bsy_q <= BUSY_CYC;
                end
                else if (i_pins.address_latch_select)
                begin
                    adr_q[acnt_q] <= i_dq[7:0];
                    acnt_q <= acnt_q + 2'h1;
                    if (acnt_q == 2'h0) col_q <= i_dq[7:0];
                end
                else
                begin
                    if (i_pins.wp_n) mem_q[col_q] <= i_dq;
                    col_q <= col_q + 8'h01;
                end
            end
            if (re_fall)
            begin
                last_q <= mem_q[col_q];
                col_q <= col_q + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb_sfh_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module tb_sfh_ctrl;
    logic clk, rst_b, req_valid, pwr_down, wp_release, word_wide;
    sfh_pkg::sfh_req_type req;
    logic rdy, done, err, oe_lo, oe_hi, rb_low, errq;
    logic [15:0] rdata, bus_out, dev_dq, bus;
    sfh_pkg::sfh_pins_type pins;
    int failures, comparisons, cyc, lat;
    // wire resolution per lane, ready/busy has a pull-up
    assign bus = {oe_hi ? bus_out[15:8] : dev_dq[15:8], oe_lo ? bus_out[7:0] : dev_dq[7:0]};
    sfh_ctrl uut (.I_CLK(clk), .I_RST_B(rst_b), .I_REQ_VALID(req_valid), .I_REQ(req),
        .O_REQ_READY(rdy), .O_DONE(done), .O_ERR(err), .O_RDATA(rdata), .I_PWR_DOWN(pwr_down),
        .I_WP_RELEASE(wp_release), .I_WORD_WIDE(word_wide), .O_PINS(pins), .O_BUS_OUT(bus_out),
        .O_BUS_OE_LO(oe_lo), .O_BUS_OE_HI(oe_hi), .I_BUS_IN(bus), .I_READY_BUSY_OD(~rb_low));
    sfh_flash_model dev (.i_clk(clk), .i_rst_b(rst_b), .i_pins(pins), .i_dq(bus), .o_dq(dev_dq),
        .o_rb_low(rb_low));
    // clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // one comparison
    task chk(input logic [15:0] e, input logic [15:0] a);
        comparisons++;
        if (a !== e)
        begin
            failures++;
            $display("[FAIL] %0t exp %h got %h", $time, e, a);
        end
    endtask
    // verdict
    task end_sim;
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // hang guard and upper lane watch during latch cycles
    always @(posedge clk)
    begin
        cyc++;
        if ((pins.command_latch_select | pins.address_latch_select) & oe_hi)
            chk(16'h0000, 16'h0001);
        if (cyc == 20000)
        begin
            failures++;
            end_sim;
        end
    end
    // one request, waits for done and keeps the error flag
    task do_req(input sfh_pkg::sfh_op_type op, input logic [15:0] d, input logic [7:0] c,
        input logic [16:0] p);
        @(posedge clk);
        req_valid <= 1'b1;
        req <= {op, d, c, p};
        do @(posedge clk); while (rdy !== 1'b1);
        req_valid <= 1'b0;
        lat = 0;
        do
        begin
            @(posedge clk);
            lat++;
        end while (done !== 1'b1 && lat < 3000);
        errq = err;
        // a request that never finishes counts as a mismatch
        if (done !== 1'b1)
        begin
            failures++;
            $display("[FAIL] %0t exp %h got %h", $time, 1'b1, done);
        end
    endtask
    // recovery: strobe high, protect low, no ready for 100 cycles
    task t_recov;
        int bad;
        bad = 0;
        lat = 0;
        while (rdy !== 1'b1 && lat < 300)
        begin
            @(posedge clk);
            lat++;
            if (rdy !== 1'b1 && (pins.we_n !== 1'b1 || pins.wp_n !== 1'b0)) bad++;
        end
        chk(16'h0000, 16'(bad));
        chk(16'h0001, {15'h0, lat >= 99 && lat <= 102});
    endtask
    // command byte on low lane
    task t_cmd;
        do_req(sfh_pkg::SFH_OP_CMD, 16'hA570, 8'h00, 17'h0_0000);
        chk(16'h0070, {8'h00, dev.cmd_q});
    endtask
    // four address bytes, column first
    task t_addr;
        do_req(sfh_pkg::SFH_OP_ADDR, 16'h0000, 8'h12, 17'h1_A5C3);
        chk(16'h12C3, {dev.adr_q[0], dev.adr_q[1]});
        chk(16'hA501, {dev.adr_q[2], dev.adr_q[3]});
    endtask
    // protected write, real writes, sequential reads, byte lane view
    task t_data;
        do_req(sfh_pkg::SFH_OP_ADDR, 16'h0000, 8'h10, 17'h0_0000);
        do_req(sfh_pkg::SFH_OP_WRITE, 16'h1111, 8'h00, 17'h0_0000);
        wp_release <= 1'b1;
        do_req(sfh_pkg::SFH_OP_ADDR, 16'h0000, 8'h10, 17'h0_0000);
        do_req(sfh_pkg::SFH_OP_READ, 16'h0000, 8'h00, 17'h0_0000);
        chk(16'hFFFF, rdata);
        do_req(sfh_pkg::SFH_OP_WRITE, 16'hBEEF, 8'h00, 17'h0_0000);
        do_req(sfh_pkg::SFH_OP_WRITE, 16'h5AA5, 8'h00, 17'h0_0000);
        do_req(sfh_pkg::SFH_OP_ADDR, 16'h0000, 8'h11, 17'h0_0000);
        do_req(sfh_pkg::SFH_OP_READ, 16'h0000, 8'h00, 17'h0_0000);
        chk(16'hBEEF, rdata);
        do_req(sfh_pkg::SFH_OP_READ, 16'h0000, 8'h00, 17'h0_0000);
        chk(16'h5AA5, rdata);
        word_wide <= 1'b0;
        do_req(sfh_pkg::SFH_OP_READ, 16'h0000, 8'h00, 17'h0_0000);
        chk(16'h00FF, rdata);
        word_wide <= 1'b1;
    endtask
    // operation busy, wait ends only after release
    task t_wait;
        do_req(sfh_pkg::SFH_OP_CMD, 16'h0030, 8'h00, 17'h0_0000);
        do_req(sfh_pkg::SFH_OP_WAIT, 16'h0000, 8'h00, 17'h0_0000);
        chk(16'h0000, {15'h0, rb_low});
        chk(16'h0001, {15'h0, lat > 10});
        chk(16'h0000, {15'h0, pins.ce_n});
    endtask
    // bad block refused without pin activity, other block passes
    task t_bad;
        do_req(sfh_pkg::SFH_OP_MARK, 16'h0000, 8'h00, 17'h1_A5C3);
        do_req(sfh_pkg::SFH_OP_ADDR, 16'h0000, 8'h77, 17'h1_A5DF);
        chk(16'h0001, {15'h0, errq});
        chk(16'h0011, {8'h00, dev.adr_q[0]});
        do_req(sfh_pkg::SFH_OP_ADDR, 16'h0000, 8'h77, 17'h0_0040);
        chk(16'h0000, {15'h0, errq});
        chk(16'h0077, {8'h00, dev.adr_q[0]});
    endtask
    // supply transition from idle restarts recovery
    task t_pwr;
        @(posedge clk);
        pwr_down <= 1'b1;
        @(posedge clk);
        pwr_down <= 1'b0;
        @(posedge clk);
        t_recov();
        do_req(sfh_pkg::SFH_OP_CMD, 16'h0090, 8'h00, 17'h0_0000);
        chk(16'h0090, {8'h00, dev.cmd_q});
    endtask
    // main sequence
    initial
    begin
        {rst_b, req_valid, pwr_down, wp_release} = 4'h0;
        word_wide = 1'b1;
        req = '0;
        {failures, comparisons, cyc} = '0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_recov();
        t_cmd();
        t_addr();
        t_data();
        t_wait();
        t_bad();
        t_pwr();
        end_sim();
    end
endmodule
`default_nettype wire
